// >>> design/phy_role_diag_defs.vh
// register map, field positions, reset values and fixed counts of the role and diagnostics block
// assumes 16-bit management registers addressed by a 16-bit register address
`ifndef PHY_ROLE_DIAG_DEFS_VH
`define PHY_ROLE_DIAG_DEFS_VH
// register addresses
`define A_NEG_CTRL 16'h0200
`define A_NEG_STAT 16'h0201
`define A_ADV_FORCE 16'h0202
`define A_ADV_ROLE 16'h0203
`define A_LP_FORCE 16'h0205
`define A_LP_ROLE 16'h0206
`define A_NEG_RESULT 16'h8001
`define A_PCS_CTRL 16'h08E6
`define A_PMA_CTRL 16'h08F6
`define A_MAC_LB 16'h803D
`define A_DIAG_CLK 16'h882C
`define A_FG_CTRL 16'h8015
`define A_FG_LEN 16'h8016
`define A_FG_CNT 16'h8017
`define A_FG_TYPE 16'h8018
`define A_FRAME_GEN_DONE 16'h801E
// field positions
`define B_NEG_EN 12
`define B_NEG_RESTART 9
`define B_COMPLETE 5
`define B_LINK 2
`define B_FORCE 12
`define B_ROLE 4
`define B_RES_LO 5
`define B_RES_HI 6
`define B_NEG_DONE 0
`define B_PCS_LB 14
`define B_PMA_LB 0
`define B_MAC_LB 0
`define B_MAC_SUP 1
`define B_REM_LB 2
`define B_REM_SUP 3
`define B_DIAG_CLK 0
`define B_FRAME_GEN_ENABLE 0
`define B_FRAME_GEN_DONE 0
// role resolution codes
`define RES_NONE 2'h0
`define RES_SLAVE 2'h1
`define RES_MASTER 2'h2
`define RES_FAULT 2'h3
// reset values
`define RST_NEG_EN 1'b1
`define RST_SUP 1'b1
`define RST_FG_LEN 16'h0040
`define RST_FG_CNT 16'h0001
`define RST_LFSR 16'hACE1
// payload types
`define PT_RANDOM 2'h0
`define PT_ONES 2'h1
`define PT_INCR 2'h2
// idle bytes between generated frames
`define FG_GAP_BYTES 8'h0C
`endif

// >>> design/phy_role_diag.v
// role negotiation, link status, loopback routing and frame generator of a single-pair phy core
// assumes a negotiation page engine and pma/pcs outside; all inputs synchronous to mclk
`timescale 1ns/1ps
`include "phy_role_diag_defs.vh"
module phy_role_diag #(
   parameter DW = 8
) (
   // clock and reset
   input wire mclk,
   input wire sys_rst,
   // configuration strap
   input wire role_strap_pin,
   // management registers
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata,
   output reg reg_rvalid,
   // negotiation page engine
   output wire neg_exchange,
   output wire [15:0] local_seed,
   output wire local_force_role,
   output wire local_role_is_master,
   input wire page_rx,
   input wire partner_force_role,
   input wire partner_role_is_master,
   input wire [15:0] partner_seed,
   input wire link_ok,
   output wire role_is_master,
   // loopback controls to pma
   output wire pma_loopback_enable,
   // mac side data
   input wire [DW-1:0] mac_txd,
   input wire mac_tx_en,
   output reg [DW-1:0] mac_rxd,
   output reg mac_rx_dv,
   // line side data
   output reg [DW-1:0] line_txd,
   output reg line_tx_en,
   input wire [DW-1:0] line_rxd,
   input wire line_rx_dv
);
   // negotiation states
   localparam ST_OFF = 2'd0;
   localparam ST_EXCH = 2'd1;
   localparam ST_UP = 2'd2;
   localparam ST_FAULT = 2'd3;
   // generator states
   localparam FG_IDLE = 2'd0;
   localparam FG_DATA = 2'd1;
   localparam FG_GAP = 2'd2;

   reg strap_done_q; // strap taken once after reset release
   reg neg_en_q; // negotiation enable
   reg adv_force_role_q; // advertise forced role
   reg adv_role_is_master_q; // advertised role
   reg lp_force_q; // captured partner force bit
   reg lp_master_q; // captured partner role bit
   reg [1:0] res_q; // role resolution code
   reg [1:0] st_q; // negotiation state
   reg was_up_q; // link seen up in this attempt
   reg link_latch_q; // latch-low link flag
   reg pcs_lb_q; // pcs loopback
   reg pma_lb_q; // pma loopback
   reg mac_lb_q; // mac side loopback
   reg mac_sup_q; // line suppress in mac loopback
   reg rem_lb_q; // remote loopback
   reg rem_sup_q; // host suppress in remote loopback
   reg diag_clk_q; // diagnostic clock enable
   reg frame_gen_enable_q; // generator enable
   reg frame_gen_done_q; // generator done flag
   reg [15:0] fg_len_q; // frame length in bytes
   reg [15:0] fg_cnt_q; // number of frames
   reg [1:0] fg_type_q; // payload type
   reg [1:0] fg_st_q; // generator state
   reg [15:0] fg_byte_q; // byte counter within frame or gap
   reg [15:0] fg_frames_q; // frames sent
   reg [15:0] lfsr_q; // seed and payload source
   reg [DW-1:0] fg_data_q; // generator output byte
   reg fg_valid_q; // generator output strobe

   wire wr_hit_ctrl = reg_wr && (reg_addr == `A_NEG_CTRL);
   wire restart_req = wr_hit_ctrl && reg_wdata[`B_NEG_RESTART];
   wire rd_stat = reg_rd && (reg_addr == `A_NEG_STAT);
   wire fg_start = reg_wr && (reg_addr == `A_FG_CTRL) && reg_wdata[`B_FRAME_GEN_ENABLE];
   wire fg_running = (fg_st_q != FG_IDLE);

   // current link: forced mode follows the pma, negotiated mode needs a finished exchange
   wire link_cur = neg_en_q ? ((st_q == ST_UP) && link_ok) : link_ok;

   assign neg_exchange = (st_q == ST_EXCH);
   assign local_seed = lfsr_q;
   assign local_force_role = adv_force_role_q;
   assign local_role_is_master = adv_role_is_master_q;
   assign role_is_master = (res_q == `RES_MASTER);
   assign pma_loopback_enable = pma_lb_q;

   // role resolution from local and partner advertisements
   reg [1:0] res_d;
   reg seed_tie;
   always @* begin
      res_d = `RES_SLAVE;
      seed_tie = 1'b0;
      if (adv_role_is_master_q != partner_role_is_master) begin
         // different roles: each side keeps its own
         res_d = adv_role_is_master_q ? `RES_MASTER : `RES_SLAVE;
      end else if (adv_force_role_q && partner_force_role) begin
         res_d = `RES_FAULT;
      end else if (adv_force_role_q != partner_force_role) begin
         // forcing end wins, the other takes the opposite
         if (adv_force_role_q) begin
            res_d = adv_role_is_master_q ? `RES_MASTER : `RES_SLAVE;
         end else begin
            res_d = adv_role_is_master_q ? `RES_SLAVE : `RES_MASTER;
         end
      end else begin
         // same preference: larger seed becomes master
         seed_tie = (lfsr_q == partner_seed);
         res_d = (lfsr_q > partner_seed) ? `RES_MASTER : `RES_SLAVE;
      end
   end

   // management register writes and strap capture
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         strap_done_q <= 1'b0;
         neg_en_q <= `RST_NEG_EN;
         adv_force_role_q <= 1'b0;
         adv_role_is_master_q <= 1'b0;
         pcs_lb_q <= 1'b0;
         pma_lb_q <= 1'b0;
         mac_lb_q <= 1'b0;
         mac_sup_q <= `RST_SUP;
         rem_lb_q <= 1'b0;
         rem_sup_q <= `RST_SUP;
         diag_clk_q <= 1'b0;
         frame_gen_enable_q <= 1'b0;
         fg_len_q <= `RST_FG_LEN;
         fg_cnt_q <= `RST_FG_CNT;
         fg_type_q <= `PT_RANDOM;
      end else begin
         // strap low (pulled down when open) gives preferred slave
         if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            adv_role_is_master_q <= role_strap_pin;
         end
         if (reg_wr) begin
            case (reg_addr)
               `A_NEG_CTRL: neg_en_q <= reg_wdata[`B_NEG_EN];
               `A_ADV_FORCE: adv_force_role_q <= reg_wdata[`B_FORCE];
               `A_ADV_ROLE: adv_role_is_master_q <= reg_wdata[`B_ROLE];
               `A_PCS_CTRL: pcs_lb_q <= reg_wdata[`B_PCS_LB];
               `A_PMA_CTRL: pma_lb_q <= reg_wdata[`B_PMA_LB];
               `A_MAC_LB: begin
                  mac_lb_q <= reg_wdata[`B_MAC_LB];
                  mac_sup_q <= reg_wdata[`B_MAC_SUP];
                  rem_lb_q <= reg_wdata[`B_REM_LB];
                  rem_sup_q <= reg_wdata[`B_REM_SUP];
               end
               `A_DIAG_CLK: diag_clk_q <= reg_wdata[`B_DIAG_CLK];
               `A_FG_CTRL: frame_gen_enable_q <= reg_wdata[`B_FRAME_GEN_ENABLE];
               `A_FG_LEN: fg_len_q <= reg_wdata;
               `A_FG_CNT: fg_cnt_q <= reg_wdata;
               `A_FG_TYPE: fg_type_q <= reg_wdata[1:0];
               default: ; // unmapped or read-only: ignored
            endcase
         end
      end
   end

   // negotiation state machine
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= ST_EXCH;
         res_q <= `RES_NONE;
         lp_force_q <= 1'b0;
         lp_master_q <= 1'b0;
         was_up_q <= 1'b0;
      end else begin
         case (st_q)
            ST_OFF: begin
               // forced configuration: role taken from the advertisement
               res_q <= adv_role_is_master_q ? `RES_MASTER : `RES_SLAVE;
               if (neg_en_q) begin
                  st_q <= ST_EXCH;
                  res_q <= `RES_NONE;
               end
            end
            ST_EXCH: begin
               was_up_q <= 1'b0;
               if (!neg_en_q) begin
                  st_q <= ST_OFF;
               end else if (page_rx && !seed_tie) begin
                  lp_force_q <= partner_force_role;
                  lp_master_q <= partner_role_is_master;
                  res_q <= res_d;
                  st_q <= (res_d == `RES_FAULT) ? ST_FAULT : ST_UP;
               end
            end
            ST_UP: begin
               if (link_ok) begin
                  was_up_q <= 1'b1;
               end
               if (!neg_en_q) begin
                  st_q <= ST_OFF;
               end else if (restart_req || (was_up_q && !link_ok)) begin
                  st_q <= ST_EXCH;
                  res_q <= `RES_NONE;
               end
            end
            ST_FAULT: begin
               // held until software asks again
               if (!neg_en_q) begin
                  st_q <= ST_OFF;
               end else if (restart_req) begin
                  st_q <= ST_EXCH;
               end
            end
            default: st_q <= ST_EXCH;
         endcase
      end
   end

   // latch-low link flag: a failure clears it, a status read reloads it
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         link_latch_q <= 1'b0;
      end else if (!link_cur) begin
         link_latch_q <= 1'b0;
      end else if (rd_stat) begin
         link_latch_q <= 1'b1;
      end
   end

   // seed and payload source, free running
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         lfsr_q <= `RST_LFSR;
      end else begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end

   // frame generator, has no tie to any frame checker
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fg_st_q <= FG_IDLE;
         fg_byte_q <= 16'h0000;
         fg_frames_q <= 16'h0000;
         frame_gen_done_q <= 1'b0;
         fg_data_q <= {DW{1'b0}};
         fg_valid_q <= 1'b0;
      end else begin
         fg_valid_q <= 1'b0;
         // a read clears done; completion in the same cycle wins
         if (reg_rd && (reg_addr == `A_FRAME_GEN_DONE)) begin
            frame_gen_done_q <= 1'b0;
         end
         case (fg_st_q)
            FG_IDLE: begin
               if (fg_start && diag_clk_q && (fg_cnt_q != 16'h0000)) begin
                  fg_st_q <= FG_DATA;
                  fg_byte_q <= 16'h0000;
                  fg_frames_q <= 16'h0000;
                  frame_gen_done_q <= 1'b0;
               end
            end
            FG_DATA: begin
               fg_valid_q <= 1'b1;
               case (fg_type_q)
                  `PT_ONES: fg_data_q <= {DW{1'b1}};
                  `PT_INCR: fg_data_q <= fg_byte_q[DW-1:0];
                  default: fg_data_q <= lfsr_q[DW-1:0];
               endcase
               fg_byte_q <= fg_byte_q + 16'h0001;
               if (fg_byte_q + 16'h0001 >= fg_len_q) begin
                  fg_st_q <= FG_GAP;
                  fg_byte_q <= 16'h0000;
                  fg_frames_q <= fg_frames_q + 16'h0001;
               end
            end
            FG_GAP: begin
               fg_byte_q <= fg_byte_q + 16'h0001;
               if (fg_byte_q[7:0] + 8'h01 >= `FG_GAP_BYTES) begin
                  fg_byte_q <= 16'h0000;
                  if (fg_frames_q >= fg_cnt_q) begin
                     fg_st_q <= FG_IDLE;
                     frame_gen_done_q <= 1'b1;
                  end else begin
                     fg_st_q <= FG_DATA;
                  end
               end
            end
            default: fg_st_q <= FG_IDLE;
         endcase
         // disabling the generator or its clock abandons the run; a start write counts as enabled
         if ((!frame_gen_enable_q && !fg_start) || !diag_clk_q) begin
            fg_st_q <= FG_IDLE;
         end
      end
   end

   // transmit source: generator, then remote return, then mac
   wire gen_src = frame_gen_enable_q && diag_clk_q;
   wire rem_active = rem_lb_q && link_cur;
   wire [DW-1:0] src_d = gen_src ? fg_data_q : (rem_active ? line_rxd : mac_txd);
   wire src_en = gen_src ? fg_valid_q : (rem_active ? line_rx_dv : mac_tx_en);

   // data routing registers
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         line_txd <= {DW{1'b0}};
         line_tx_en <= 1'b0;
         mac_rxd <= {DW{1'b0}};
         mac_rx_dv <= 1'b0;
      end else begin
         line_txd <= src_d;
         // silent line in pcs loopback and suppressed mac loopback
         line_tx_en <= src_en && !pcs_lb_q && !(mac_lb_q && mac_sup_q);
         if (pcs_lb_q) begin
            mac_rxd <= src_d;
            mac_rx_dv <= src_en;
         end else if (mac_lb_q) begin
            mac_rxd <= mac_txd;
            mac_rx_dv <= mac_tx_en;
         end else if (rem_active && rem_sup_q) begin
            mac_rxd <= {DW{1'b0}};
            mac_rx_dv <= 1'b0;
         end else begin
            mac_rxd <= line_rxd;
            mac_rx_dv <= line_rx_dv;
         end
      end
   end

   // register read mux, answer one cycle after the strobe
   reg [15:0] rd_d;
   always @* begin
      rd_d = 16'h0000;
      case (reg_addr)
         `A_NEG_CTRL: rd_d[`B_NEG_EN] = neg_en_q;
         `A_NEG_STAT: begin
            rd_d[`B_COMPLETE] = (st_q == ST_UP) && link_ok;
            rd_d[`B_LINK] = link_latch_q;
         end
         `A_ADV_FORCE: rd_d[`B_FORCE] = adv_force_role_q;
         `A_ADV_ROLE: rd_d[`B_ROLE] = adv_role_is_master_q;
         `A_LP_FORCE: rd_d[`B_FORCE] = lp_force_q;
         `A_LP_ROLE: rd_d[`B_ROLE] = lp_master_q;
         `A_NEG_RESULT: begin
            rd_d[`B_RES_HI:`B_RES_LO] = res_q;
            rd_d[`B_NEG_DONE] = (st_q == ST_UP);
         end
         `A_PCS_CTRL: rd_d[`B_PCS_LB] = pcs_lb_q;
         `A_PMA_CTRL: rd_d[`B_PMA_LB] = pma_lb_q;
         `A_MAC_LB: rd_d[3:0] = {rem_sup_q, rem_lb_q, mac_sup_q, mac_lb_q};
         `A_DIAG_CLK: rd_d[`B_DIAG_CLK] = diag_clk_q;
         `A_FG_CTRL: rd_d[`B_FRAME_GEN_ENABLE] = frame_gen_enable_q;
         `A_FG_LEN: rd_d = fg_len_q;
         `A_FG_CNT: rd_d = fg_cnt_q;
         `A_FG_TYPE: rd_d[1:0] = fg_type_q;
         `A_FRAME_GEN_DONE: rd_d[`B_FRAME_GEN_DONE] = frame_gen_done_q;
         default: rd_d = 16'h0000;
      endcase
   end

   // read answer registers
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_d;
         end
      end
   end
endmodule

// >>> sim/phy_role_diag_asserts.sv
// concurrent checks on the role, link status and loopback ports
// assumes it is bound into phy_role_diag; all signals on mclk
`timescale 1ns/1ps
module phy_role_diag_asserts (
   // clock and reset
   input wire mclk, input wire sys_rst,
   // management registers
   input wire reg_wr, input wire reg_rd, input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata, input wire [15:0] reg_rdata, input wire reg_rvalid,
   // negotiation
   input wire neg_exchange, input wire [15:0] local_seed, input wire local_force_role,
   input wire local_role_is_master, input wire page_rx, input wire partner_force_role,
   input wire partner_role_is_master, input wire [15:0] partner_seed,
   input wire link_ok, input wire role_is_master,
   // loopback and line
   input wire pma_loopback_enable, input wire line_tx_en
);
   // shadow state of negotiation enable, fault and loopback bits
   reg neg_en_q, fault_q, pcs_q, pma_q;
   // a page that the design takes
   wire acc = neg_exchange && page_rx && (partner_seed != local_seed);
   wire same_role = local_role_is_master == partner_role_is_master;
   wire ctrl_wr = reg_wr && reg_addr == 16'h0200;
   // track what the registers should hold
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         neg_en_q <= 1'b1;
         fault_q <= 1'b0;
         pcs_q <= 1'b0;
         pma_q <= 1'b0;
      end else begin
         if (acc)
            fault_q <= local_force_role && partner_force_role && same_role;
         if (ctrl_wr && (reg_wdata[9] || !reg_wdata[12]))
            fault_q <= 1'b0;
         if (ctrl_wr)
            neg_en_q <= reg_wdata[12];
         if (reg_wr && reg_addr == 16'h08E6)
            pcs_q <= reg_wdata[14];
         if (reg_wr && reg_addr == 16'h08F6)
            pma_q <= reg_wdata[0];
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_rvalid_pulse: assert property (reg_rvalid == $past(reg_rd))
      else $error("read answer not one cycle after strobe");
   a_exch_ends: assert property (acc |=> !neg_exchange)
      else $error("exchange did not end on page");
   a_seed_master: assert property (acc && !local_force_role && !partner_force_role && same_role
      && (local_seed > partner_seed) |=> role_is_master)
      else $error("equal preferences not settled by seed");
   a_forced_wins: assert property (acc && (local_force_role != partner_force_role) && same_role
      |=> role_is_master == $past(local_role_is_master == local_force_role))
      else $error("forcing end did not win");
   a_diff_roles: assert property (acc && !same_role
      |=> role_is_master == $past(local_role_is_master))
      else $error("different roles not kept");
   a_fault_hold: assert property (acc && local_force_role && partner_force_role && same_role
      |=> (!neg_exchange && !role_is_master) [*2])
      else $error("fault did not stop negotiation");
   a_fault_status: assert property (fault_q && reg_rd && reg_addr == 16'h0201
      |=> reg_rdata[5] == 1'b0 && reg_rdata[2] == 1'b0)
      else $error("status shows link after fault");
   a_drop_restart: assert property (neg_en_q && !fault_q && !neg_exchange && $fell(link_ok)
      |=> neg_exchange)
      else $error("link drop did not restart negotiation");
   a_pcs_silent: assert property (pcs_q && $past(pcs_q) |-> !line_tx_en)
      else $error("line driven in pcs loopback");
   a_pma_follow: assert property (pma_loopback_enable == pma_q)
      else $error("pma loopback output differs from register");
   c_page: cover property (acc);
   c_fault_link: cover property (fault_q && link_ok);
   c_drop: cover property ($fell(link_ok) && !neg_exchange);
endmodule

// >>> sim/lp_model.sv
// behavioural link partner: sends one page, raises and drops the link
// assumes tasks are called from the bench; drives just after mclk rises
`timescale 1ns/1ps
module lp_model (
   input wire mclk,
   input wire [15:0] local_seed,
   output reg page_rx,
   output reg partner_force_role,
   output reg partner_role_is_master,
   output reg [15:0] partner_seed,
   output reg link_ok,
   output reg [7:0] line_rxd,
   output reg line_rx_dv
);
   initial begin
      page_rx = 1'b0;
      partner_force_role = 1'b0;
      partner_role_is_master = 1'b0;
      partner_seed = 16'h0000;
      link_ok = 1'b0;
      line_rxd = 8'h00;
      line_rx_dv = 1'b0;
   end
   // idle receive lane toggles so a stale value is never mistaken for data
   always @(posedge mclk)
      line_rxd <= ~line_rxd;
   // one page; lo puts the partner seed below the local one
   task send_page(input f, input m, input lo);
      begin
         @(posedge mclk);
         #1 page_rx = 1'b1;
         partner_force_role = f;
         partner_role_is_master = m;
         partner_seed = lo ? local_seed - 16'h1 : local_seed + 16'h1;
         @(posedge mclk);
         #1 page_rx = 1'b0;
         partner_force_role = ~f;
         partner_role_is_master = ~m;
         partner_seed = ~partner_seed;
      end
   endtask
   task set_rx(input v);
      begin
         @(posedge mclk);
         #1 line_rx_dv = v;
      end
   endtask
   task set_link(input v);
      begin
         @(posedge mclk);
         #1 link_ok = v;
      end
   endtask
endmodule

// >>> sim/phy_role_diag_tb.sv
// bench for phy_role_diag: register tasks, partner model, loopback and generator
// assumes lp_model and the checker are compiled alongside
`timescale 1ns/1ps
module phy_role_diag_tb;
   reg mclk, sys_rst, role_strap_pin, reg_wr, reg_rd, mac_tx_en;
   reg [15:0] reg_addr, reg_wdata, rd;
   reg [7:0] mac_txd;
   reg [6:0] t;
   wire [15:0] reg_rdata, local_seed, partner_seed;
   wire [7:0] mac_rxd, line_txd, line_rxd;
   wire reg_rvalid, neg_exchange, local_force_role, local_role_is_master, page_rx;
   wire partner_force_role, partner_role_is_master, link_ok, role_is_master;
   wire pma_loopback_enable, mac_rx_dv, line_tx_en, line_rx_dv;
   integer n_errors, compares, cyc, i;
   // rows: local force, role, partner force, role, seed below, result code
   localparam [55:0] TAB = {7'b0101001, 7'b1000101, 7'b0111101, 7'b0011101,
      7'b1100010, 7'b1010111, 7'b1111111, 7'b0000001};
   phy_role_diag DUT (.mclk(mclk), .sys_rst(sys_rst), .role_strap_pin(role_strap_pin),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .neg_exchange(neg_exchange),
      .local_seed(local_seed), .local_force_role(local_force_role),
      .local_role_is_master(local_role_is_master), .page_rx(page_rx),
      .partner_force_role(partner_force_role), .partner_role_is_master(partner_role_is_master),
      .partner_seed(partner_seed), .link_ok(link_ok), .role_is_master(role_is_master),
      .pma_loopback_enable(pma_loopback_enable), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en),
      .mac_rxd(mac_rxd), .mac_rx_dv(mac_rx_dv), .line_txd(line_txd), .line_tx_en(line_tx_en),
      .line_rxd(line_rxd), .line_rx_dv(line_rx_dv));
   lp_model u_lp (.mclk(mclk), .local_seed(local_seed), .page_rx(page_rx),
      .partner_force_role(partner_force_role), .partner_role_is_master(partner_role_is_master),
      .partner_seed(partner_seed), .link_ok(link_ok), .line_rxd(line_rxd),
      .line_rx_dv(line_rx_dv));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task check(input string nm, input [15:0] exp, input [15:0] got);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task wr(input [15:0] a, input [15:0] d);
      begin
         @(posedge mclk);
         #1 reg_wr = 1'b1;
         reg_addr = a;
         reg_wdata = d;
         @(posedge mclk);
         #1 reg_wr = 1'b0;
      end
   endtask
   task rd_reg(input [15:0] a, output [15:0] d);
      begin
         @(posedge mclk);
         #1 reg_rd = 1'b1;
         reg_addr = a;
         @(posedge mclk);
         #1 reg_rd = 1'b0;
         check("rvalid", 16'h1, {15'h0, reg_rvalid});
         d = reg_rdata;
      end
   endtask
   task stop_test;
      begin
         $display("comparisons %0d mismatches %0d", compares, n_errors);
         if (n_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // hang guard
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         stop_test;
      end
   end
   initial begin
      {sys_rst, role_strap_pin, reg_wr, reg_rd, mac_tx_en} = 5'b10000;
      reg_addr = 16'h0;
      reg_wdata = 16'h0;
      mac_txd = 8'h5A;
      n_errors = 0;
      compares = 0;
      cyc = 0;
      repeat (10) @(posedge mclk);
      #1 sys_rst = 1'b0;
      repeat (2) @(posedge mclk);
      // reset values
      rd_reg(16'h0200, rd);
      check("neg_enable", 16'h1000, rd & 16'h1000);
      rd_reg(16'h0203, rd);
      check("adv_role", 16'h0, rd & 16'h0010);
      rd_reg(16'h0202, rd);
      check("adv_force", 16'h0, rd & 16'h1000);
      rd_reg(16'h803D, rd);
      check("suppress", 16'h000A, rd & 16'h000F);
      rd_reg(16'h1234, rd);
      check("unmapped", 16'h0, rd);
      $display("test reset done");
      // preferred slave both ends, local seed larger
      u_lp.send_page(1'b0, 1'b0, 1'b1);
      check("exchange", 16'h0, {15'h0, neg_exchange});
      rd_reg(16'h8001, rd);
      check("result", 16'h0041, rd & 16'h0061);
      rd_reg(16'h0205, rd);
      check("lp_force", 16'h0, rd & 16'h1000);
      rd_reg(16'h0206, rd);
      check("lp_role", 16'h0, rd & 16'h0010);
      u_lp.set_link(1'b1);
      rd_reg(16'h0201, rd);
      check("complete", 16'h0020, rd & 16'h0020);
      rd_reg(16'h0201, rd);
      check("link_now", 16'h0024, rd & 16'h0024);
      u_lp.set_link(1'b0);
      @(posedge mclk);
      #1 check("restart", 16'h1, {15'h0, neg_exchange});
      u_lp.send_page(1'b0, 1'b0, 1'b1);
      u_lp.set_link(1'b1);
      rd_reg(16'h0201, rd);
      check("link_latched", 16'h0, rd & 16'h0004);
      rd_reg(16'h0201, rd);
      check("link_again", 16'h0004, rd & 16'h0004);
      u_lp.set_link(1'b0);
      $display("test link done");
      // eight role combinations, each resolution rule at least once
      for (i = 0; i < 8; i = i + 1) begin
         t = TAB[i*7 +: 7];
         wr(16'h0202, {3'h0, t[6], 12'h0});
         wr(16'h0203, {11'h0, t[5], 4'h0});
         wr(16'h0200, 16'h1200);
         check("exchange", 16'h1, {15'h0, neg_exchange});
         u_lp.send_page(t[4], t[3], t[2]);
         rd_reg(16'h8001, rd);
         check("result", {9'h0, t[1:0], 5'h0}, rd & 16'h0060);
         check("role", {15'h0, t[1:0] == 2'h2}, {15'h0, role_is_master});
         if (t[1:0] == 2'h3) begin
            u_lp.set_link(1'b1);
            rd_reg(16'h0201, rd);
            check("fault_status", 16'h0, rd & 16'h0024);
            u_lp.set_link(1'b0);
         end
      end
      $display("test roles done");
      // loopbacks with mac traffic
      mac_tx_en = 1'b1;
      wr(16'h08E6, 16'h4000);
      repeat (2) @(posedge mclk);
      #1 check("pcs_rx", 16'h015A, {7'h0, mac_rx_dv, mac_rxd});
      check("pcs_line", 16'h0, {15'h0, line_tx_en});
      wr(16'h08E6, 16'h0000);
      mac_txd = 8'hC3;
      wr(16'h803D, 16'h0003);
      repeat (2) @(posedge mclk);
      #1 check("mac_rx", 16'h01C3, {7'h0, mac_rx_dv, mac_rxd});
      check("mac_line", 16'h0, {15'h0, line_tx_en});
      wr(16'h803D, 16'h0000);
      repeat (2) @(posedge mclk);
      #1 check("line_tx", 16'h01C3, {7'h0, line_tx_en, line_txd});
      check("host_rx", 16'h0, {15'h0, mac_rx_dv});
      // remote loopback with host suppress while the link is up
      wr(16'h803D, 16'h000C);
      u_lp.set_link(1'b1);
      u_lp.set_rx(1'b1);
      repeat (2) @(posedge mclk);
      #1 check("rem_tx", {7'h0, 1'b1, ~line_rxd}, {7'h0, line_tx_en, line_txd});
      check("rem_sup", 16'h0, {15'h0, mac_rx_dv});
      $display("test loopback done");
      // frame generator replaces mac data
      mac_tx_en = 1'b0;
      wr(16'h882C, 16'h0001);
      wr(16'h8015, 16'h0001);
      repeat (5) @(posedge mclk);
      #1 check("gen_line", 16'h1, {15'h0, line_tx_en});
      rd = 16'h0;
      for (i = 0; i < 80 && rd[0] !== 1'b1; i = i + 1)
         rd_reg(16'h801E, rd);
      check("gen_done", 16'h1, rd & 16'h0001);
      // pma loopback after forcing the link
      wr(16'h0200, 16'h0000);
      wr(16'h08F6, 16'h0001);
      check("pma_lb", 16'h1, {15'h0, pma_loopback_enable});
      // second reset with the strap pulled high: advertised role becomes master
      role_strap_pin = 1'b1;
      sys_rst = 1'b1;
      @(posedge mclk);
      #1 sys_rst = 1'b0;
      rd_reg(16'h0203, rd);
      check("strap_role", 16'h0010, rd & 16'h0010);
      $display("test diagnostics done");
      stop_test;
   end
endmodule
bind phy_role_diag phy_role_diag_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .neg_exchange(neg_exchange),
   .local_seed(local_seed), .local_force_role(local_force_role),
   .local_role_is_master(local_role_is_master), .page_rx(page_rx),
   .partner_force_role(partner_force_role), .partner_role_is_master(partner_role_is_master),
   .partner_seed(partner_seed), .link_ok(link_ok), .role_is_master(role_is_master),
   .pma_loopback_enable(pma_loopback_enable), .line_tx_en(line_tx_en));
